// *** tb_tpr_retimer.sv ***
/*
  Self-checking bench for tpr_retimer against a reference flip-flop.
  Assumes 125 MHz clk; one wanted bit per fall of the selected gate.
*/
`timescale 1ns/1ps
`include "tpr_cfg.svh"
module tb_tpr_retimer;
  import tpr_pkg::*;
  logic      clk = 1'b0;
  logic      nrst = 1'b0;
  tpr_mode_t channel_mode_selector = `TPR_MODE_12;
  logic [2:0] gates = 3'h7;
  logic      pcm_stretched = 1'b0;
  logic      pcm_stretched_n = 1'b1;
  logic      gate_select_output, dummy_detect_enable, retimed_pcm;
  logic      retimed_pcm_n, pcm_out_1, pcm_out_2;
  logic      monitor_g, monitor_k, monitor_l, st;
  logic [11:0] w1, w2;
  logic [1:0]  jk;
  int        bad_count = 0, checked = 0, mi = 0, w;
  // ------------------------------------------
  // harness
  // ------------------------------------------
  always #4 clk = ~clk;
  tpr_retimer dut
  (
    .clk, .nrst, .channel_mode_selector, .gate_576(gates[0]),
    .gate_1152(gates[1]), .gate_2304(gates[2]), .pcm_stretched,
    .pcm_stretched_n, .gate_select_output, .dummy_detect_enable,
    .retimed_pcm, .retimed_pcm_n, .pcm_out_1, .pcm_out_2, .monitor_g,
    .monitor_k, .monitor_l
  );
  tpr_line_sink u_sink1 (.clk, .line(pcm_out_1), .last_w(w1));
  tpr_line_sink u_sink2 (.clk, .line(pcm_out_2), .last_w(w2));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp,
                     input string what);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one bit: junk while the gate is high, wanted bit after it falls
  task automatic send(input logic j, input logic k);
    repeat (8)
    begin
      @(posedge clk);
      gates[mi]       <= 1'b1;
      pcm_stretched   <= 1'($urandom);
      pcm_stretched_n <= 1'($urandom);
    end
    #1;
    chk(gate_select_output, 1'b1, "gate_sel");
    @(posedge clk);
    gates[mi]       <= 1'b0;
    pcm_stretched   <= j;
    pcm_stretched_n <= k;
    st = (j & k) ? !st : (j ? 1'b1 : (k ? 1'b0 : st));
    tick(3);
    #1;
    chk(retimed_pcm, st, "retimed");
    chk(retimed_pcm_n, !st, "retimed_n");
    chk(gate_select_output, 1'b0, "gate_sel");
    tick(1);
    #1;
    chk(pcm_out_1, st, "pcm_out_1");
    chk(pcm_out_2, st, "pcm_out_2");
    tick(w);
    #1;
    chk(pcm_out_1, 1'b0, "pcm_out_1 end");
    chk(monitor_g, 1'b1, "monitor_g");
    if (st)
      chk({monitor_k, monitor_l}, 2'h3, "monitor_kl");
    tick(1);
    #1;
    if (st)
      chk(w2, 12'(w), "width");
    if (st)
      chk(w1, 12'(w), "width 1");
    tick(15);
  endtask
  // main sequence: every mode, fixed then random input pairs
  initial
  begin
    void'($urandom(39906));
    st = 1'b0;
    tick(2);
    nrst <= 1'b1;
    for (int m = 0; m < 3; m++)
    begin
      mi = m;
      w = (m == 0) ? `TPR_PW12_CYC :
          (m == 1) ? `TPR_PW24_CYC : `TPR_PW48_CYC;
      channel_mode_selector <= 2'(m);
      tick(3);
      #1;
      chk(dummy_detect_enable, 12'(m == 0), "dummy_en");
      for (int i = 0; i < 8; i++)
      begin
        jk = (i < 4) ? 2'(8'h8D >> (6 - 2 * i)) : 2'($urandom);
        send(jk[1], jk[0]);
      end
      gates <= 3'h7;
      tick(`TPR_ACT_CYC + 20);
      #1;
      chk({monitor_g, monitor_k, monitor_l}, 3'h0, "monitors");
    end
    // unused selector code: gate toggles must never reach the flip-flop;
    // the switch itself may look like a fall, so pcm holds at that moment
    tick(1);
    channel_mode_selector <= 2'h3;
    pcm_stretched   <= 1'b0;
    pcm_stretched_n <= 1'b0;
    tick(4);
    pcm_stretched   <= !st;
    pcm_stretched_n <= st;
    repeat (4)
    begin
      gates <= 3'h0;
      tick(4);
      gates <= 3'h7;
      tick(4);
    end
    #1;
    chk(gate_select_output, 1'b0, "gate_sel idle");
    chk(dummy_detect_enable, 12'h000, "dummy_en idle");
    chk(retimed_pcm, st, "retimed idle");
    report_and_stop();
  end
  // watchdog well beyond the expected run of about 17000 cycles
  initial
  begin
    tick(40000);
    bad_count++;
    report_and_stop();
  end
endmodule

// *** tpr_activity.sv ***
/*
  Retriggerable activity flag: set by every pulse, cleared after a quiet
  timeout.
  Assumes pulse input is synchronous to clk.
*/
`timescale 1ns/1ps
`include "tpr_cfg.svh"

module tpr_activity
(
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             pulse,
  input  wire tpr_pkg::tpr_cnt_t timeout,
  output logic                  active
);
  import tpr_pkg::*;

  tpr_cnt_t cnt_q;
  tpr_cnt_t cnt_d;
  logic     act_q;
  logic     act_d;

  // ----------------------------------------------------------------
  // retrigger counter
  // ----------------------------------------------------------------
  // a pulse reloads the count, so a pulse in the last quiet cycle wins
  always_comb
  begin
    cnt_d = cnt_q;
    act_d = act_q;
    if (pulse)
    begin
      cnt_d = timeout;
      act_d = 1'b1;
    end
    else if (cnt_q != '0)
    begin
      cnt_d = cnt_q - tpr_cnt_t'(1);
      act_d = (cnt_q != tpr_cnt_t'(1));
    end
    else
    begin
      act_d = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cnt_q <= '0;
      act_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      act_q <= act_d;
    end
  end

  assign active = act_q;
endmodule

// *** tpr_cfg.svh ***
/*
  Constants for the timed pcm retimer: channel mode codes, output pulse
  widths and activity timeout counts, all in 125 MHz clock cycles.
  Assumes inclusion by bare name from the package and the modules.
*/
// Functional notes
// - retiming flip-flop updates only on falling edge of selected gate
// - flip-flop true output follows pcm, complement follows inverted pcm
// - 6/12-channel mode samples with the 576 kHz gate
// - 24-channel mode samples with the 1152 kHz gate
// - 48-channel mode samples with the 2304 kHz gate
// - dummy bits during active 576 kHz gate are dropped at trailing edge
// - true output feeds both pcm channels, complement feeds generator detector
// - pulse width 3.57 us, 1.736 us or 0.434 us per mode
// - generator activity flag while pulses are produced, shown on monitor G
// - channel one activity flag while pulsing, shown on monitor K
// - channel two identical to channel one, activity shown on monitor L
// - dummy-train detection disabled in 24 and 48 channel modes
// - three-position mode selector chooses gate routed to flip-flop
`ifndef TPR_CFG_SVH
`define TPR_CFG_SVH

// channel mode selector codes
`define TPR_MODE_12         2'h0
`define TPR_MODE_24         2'h1
`define TPR_MODE_48         2'h2

`define TPR_CLK_MHZ         125
// pulse widths in nanoseconds; cycles rounded down, never below 1
`define TPR_PW12_NS         3570
`define TPR_PW24_NS         1736
`define TPR_PW48_NS         434
`define TPR_CYC(ns)         ((((ns) * `TPR_CLK_MHZ) / 1000) < 1 ? 1 : \
                             (((ns) * `TPR_CLK_MHZ) / 1000))
`define TPR_PW12_CYC        `TPR_CYC(`TPR_PW12_NS)
`define TPR_PW24_CYC        `TPR_CYC(`TPR_PW24_NS)
`define TPR_PW48_CYC        `TPR_CYC(`TPR_PW48_NS)

// activity timeout: 16 bit periods of the slowest gate (576 kHz)
`define TPR_ACT_NS          27778
`define TPR_ACT_CYC         ((`TPR_ACT_NS * `TPR_CLK_MHZ + 999) / 1000)
`define TPR_CNT_W           12

`endif

// *** tpr_line_sink.sv ***
/*
  Line output model: measures the width of each pcm pulse it receives.
  Assumes pulses synchronous to clk.
*/
`timescale 1ns/1ps
module tpr_line_sink
(
  input  wire logic clk,
  input  wire logic line,
  output logic [11:0] last_w
);
  logic [11:0] run_q = 12'h000;
  // the receptacle only sees widths, reported at each pulse end
  always @(posedge clk)
  begin
    if (line)
      run_q <= run_q + 12'h001;
    else if (run_q != 12'h000)
    begin
      last_w <= run_q;
      run_q  <= 12'h000;
    end
  end
endmodule

// *** tpr_pkg.sv ***
/*
  Types for the timed pcm retimer.
  Assumes tpr_cfg.svh is on the include path.
*/
`include "tpr_cfg.svh"

package tpr_pkg;
  typedef logic [1:0] tpr_mode_t;
  typedef logic [`TPR_CNT_W-1:0] tpr_cnt_t;
  // output pulse shaper states, one-hot
  typedef enum logic [1:0]
  {
    TPR_IDLE  = 2'h1,
    TPR_PULSE = 2'h2
  } tpr_pst_t;
endpackage

// *** tpr_retimer.sv ***
/*
  Timed pcm retimer: samples stretched pcm on the trailing edge of the
  mode-selected timing gate, shapes two identical output pulse channels
  and keeps three activity flags for the service monitor.
  Assumes all inputs are synchronous to clk and the gates are well below
  the clock rate (at least a few clocks high and low).
*/
`timescale 1ns/1ps
`include "tpr_cfg.svh"

module tpr_retimer
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire tpr_pkg::tpr_mode_t channel_mode_selector,
  input  wire logic              gate_576,
  input  wire logic              gate_1152,
  input  wire logic              gate_2304,
  input  wire logic              pcm_stretched,
  input  wire logic              pcm_stretched_n,
  output logic                   gate_select_output,
  output logic                   dummy_detect_enable,
  output logic                   retimed_pcm,
  output logic                   retimed_pcm_n,
  output logic                   pcm_out_1,
  output logic                   pcm_out_2,
  output logic                   monitor_g,
  output logic                   monitor_k,
  output logic                   monitor_l
);
  import tpr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic     gate_q,  gate_d;
  logic     gprev_q, gprev_d;
  logic     dde_q,   dde_d;
  logic     rt_q,    rt_d;
  logic     rtn_q,   rtn_d;
  logic     samp_q,  samp_d;
  tpr_cnt_t pw_q,    pw_d;
  tpr_pst_t pst_q,   pst_d;
  tpr_cnt_t pwc_q,   pwc_d;
  logic     out_q,   out_d;
  logic     genp_q,  genp_d;
  logic     act_g,   act_k,  act_l;
  logic     mon_q[3];
  logic     act[3];

  // ----------------------------------------------------------------
  // gate selection and sampling
  // ----------------------------------------------------------------
  // gate is registered before edge detection so the edge is clean and
  // aligned with the registered mode-dependent pulse width
  always_comb
  begin
    gate_d  = 1'b0;
    dde_d   = 1'b0;
    pw_d    = tpr_cnt_t'(`TPR_PW12_CYC);
    case (channel_mode_selector)
      `TPR_MODE_12:
      begin
        gate_d = gate_576;
        dde_d  = 1'b1;
        pw_d   = tpr_cnt_t'(`TPR_PW12_CYC);
      end
      `TPR_MODE_24:
      begin
        gate_d = gate_1152;
        dde_d  = 1'b0;
        pw_d   = tpr_cnt_t'(`TPR_PW24_CYC);
      end
      `TPR_MODE_48:
      begin
        gate_d = gate_2304;
        dde_d  = 1'b0;
        pw_d   = tpr_cnt_t'(`TPR_PW48_CYC);
      end
      default:
      begin
        gate_d = 1'b0;   // unused selector code holds the retimer still
        dde_d  = 1'b0;
        pw_d   = tpr_cnt_t'(`TPR_PW12_CYC);
      end
    endcase
    gprev_d = gate_q;
    samp_d  = gprev_q & ~gate_q;   // trailing edge of the selected gate
    rt_d    = rt_q;
    rtn_d   = rtn_q;
    // j-k action: set on pcm, clear on complement, hold when both low;
    // sampling at the gate fall skips dummy bits sent while it was high
    if (gprev_q && !gate_q)
    begin
      if (pcm_stretched && !pcm_stretched_n)
      begin
        rt_d  = 1'b1;
        rtn_d = 1'b0;
      end
      else if (!pcm_stretched && pcm_stretched_n)
      begin
        rt_d  = 1'b0;
        rtn_d = 1'b1;
      end
      else if (pcm_stretched && pcm_stretched_n)
      begin
        rt_d  = ~rt_q;   // both high toggles, as a j-k does
        rtn_d = rt_q;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      gate_q  <= 1'b0;
      gprev_q <= 1'b0;
      dde_q   <= 1'b0;
      pw_q    <= tpr_cnt_t'(`TPR_PW12_CYC);
      samp_q  <= 1'b0;
      rt_q    <= 1'b0;
      rtn_q   <= 1'b1;
    end
    else
    begin
      gate_q  <= gate_d;
      gprev_q <= gprev_d;
      dde_q   <= dde_d;
      pw_q    <= pw_d;
      samp_q  <= samp_d;
      rt_q    <= rt_d;
      rtn_q   <= rtn_d;
    end
  end

  // ----------------------------------------------------------------
  // output pulse shaper, shared by both channels
  // ----------------------------------------------------------------
  // one shaper drives both outputs so the channels stay identical
  always_comb
  begin
    pst_d  = pst_q;
    pwc_d  = pwc_q;
    out_d  = 1'b0;
    genp_d = samp_q & rtn_q;       // complement activity per sample
    case (pst_q)
      TPR_IDLE:
      begin
        if (samp_q && rt_q)
        begin
          pst_d = TPR_PULSE;
          pwc_d = pw_q - tpr_cnt_t'(1);
          out_d = 1'b1;
        end
      end
      TPR_PULSE:
      begin
        if (pwc_q == '0)
        begin
          pst_d = TPR_IDLE;
        end
        else
        begin
          pwc_d = pwc_q - tpr_cnt_t'(1);
          out_d = 1'b1;
        end
      end
      default:
      begin
        pst_d = TPR_IDLE;
        pwc_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pst_q  <= TPR_IDLE;
      pwc_q  <= '0;
      out_q  <= 1'b0;
      genp_q <= 1'b0;
    end
    else
    begin
      pst_q  <= pst_d;
      pwc_q  <= pwc_d;
      out_q  <= out_d;
      genp_q <= genp_d;
    end
  end

  // ----------------------------------------------------------------
  // activity flags for monitor inputs g, k and l
  // ----------------------------------------------------------------
  // channels k and l see the same pulse; each keeps its own flag
  tpr_activity u_act_g
  (
    .clk     (clk),
    .nrst    (nrst),
    .pulse   (genp_q | (samp_q & rt_q)),
    .timeout (tpr_cnt_t'(`TPR_ACT_CYC)),
    .active  (act_g)
  );

  tpr_activity u_act_k
  (
    .clk     (clk),
    .nrst    (nrst),
    .pulse   (out_q),
    .timeout (tpr_cnt_t'(`TPR_ACT_CYC)),
    .active  (act_k)
  );

  tpr_activity u_act_l
  (
    .clk     (clk),
    .nrst    (nrst),
    .pulse   (out_q),
    .timeout (tpr_cnt_t'(`TPR_ACT_CYC)),
    .active  (act_l)
  );

  assign act[0] = act_g;
  assign act[1] = act_k;
  assign act[2] = act_l;

  // registered copies so every output leaves from a flip-flop
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_mon
      always_ff @(posedge clk)
      begin
        if (!nrst)
          mon_q[gi] <= 1'b0;
        else
          mon_q[gi] <= act[gi];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign gate_select_output  = gate_q;
  assign dummy_detect_enable = dde_q;
  assign retimed_pcm         = rt_q;
  assign retimed_pcm_n       = rtn_q;
  assign pcm_out_1           = out_q;
  assign pcm_out_2           = out_q;
  assign monitor_g           = mon_q[0];
  assign monitor_k           = mon_q[1];
  assign monitor_l           = mon_q[2];
endmodule

// *** tpr_retimer_properties.sv ***
/*
  Concurrent checks on the tpr_retimer ports.
  Assumes one 125 MHz clock and synchronous active-low nrst.
*/
`timescale 1ns/1ps
`include "tpr_cfg.svh"
module tpr_retimer_properties
(
  input wire logic               clk,
  input wire logic               nrst,
  input wire tpr_pkg::tpr_mode_t channel_mode_selector,
  input wire logic               gate_576,
  input wire logic               gate_1152,
  input wire logic               gate_2304,
  input wire logic               gate_select_output,
  input wire logic               dummy_detect_enable,
  input wire logic               retimed_pcm,
  input wire logic               retimed_pcm_n,
  input wire logic               pcm_out_1,
  input wire logic               pcm_out_2,
  input wire logic               monitor_g,
  input wire logic               monitor_k,
  input wire logic               monitor_l
);
  import tpr_pkg::*;
  localparam int ACT = `TPR_ACT_CYC + 16;
  logic [1:0]  fall_q;
  logic [11:0] hi_q;
  logic [12:0] quiet_q;
  logic        sel;
  int          exp_w;
  // -------------------------------------------
  // helpers
  // -------------------------------------------
  // gate and pulse width that the selector should pick
  always_comb
  begin
    case (channel_mode_selector)
      `TPR_MODE_12: sel = gate_576;
      `TPR_MODE_24: sel = gate_1152;
      `TPR_MODE_48: sel = gate_2304;
      default:      sel = 1'b0;
    endcase
    exp_w = (channel_mode_selector == `TPR_MODE_24) ? `TPR_PW24_CYC :
            (channel_mode_selector == `TPR_MODE_48) ? `TPR_PW48_CYC :
            `TPR_PW12_CYC;
  end
  // fall history, pulse length, quiet time (saturates, never wraps)
  // cleared in reset so the quiet check is live from the start
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      fall_q  <= 2'h0;
      hi_q    <= 12'h000;
      quiet_q <= 13'h0000;
    end
    else
    begin
      fall_q  <= {fall_q[0], $fell(gate_select_output)};
      hi_q    <= pcm_out_1 ? hi_q + 12'h001 : 12'h000;
      quiet_q <= pcm_out_1 ? 13'h0000 :
                 (quiet_q[12] ? quiet_q : quiet_q + 13'h0001);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence pulse_s;
    ##1 pcm_out_1 ##[1:3] (monitor_k && monitor_l && monitor_g);
  endsequence
  comp_pair_a: assert property (retimed_pcm_n == !retimed_pcm)
    else $error("retimed outputs not complementary");
  fall_only_a: assert property ($changed(retimed_pcm) |-> fall_q[0])
    else $error("retimed output moved without gate fall");
  pulse_follow_a: assert property ($rose(retimed_pcm) |-> pulse_s)
    else $error("no pulse or activity after retimed one");
  width_mode_a: assert property ($fell(pcm_out_1) |-> hi_q == exp_w)
    else $error("pulse width wrong for mode");
  twin_out_a: assert property (pcm_out_1 == pcm_out_2)
    else $error("output channels differ");
  dummy_en_a: assert property ($past(nrst) && $past(nrst, 2) |->
    dummy_detect_enable == $past(channel_mode_selector == `TPR_MODE_12))
    else $error("dummy detect enable wrong");
  gate_sel_a: assert property ($past(nrst) && $past(nrst, 2) |->
    gate_select_output == $past(sel))
    else $error("wrong gate selected");
  quiet_clear_a: assert property (quiet_q > ACT |->
    !monitor_k && !monitor_l)
    else $error("activity flag stuck after quiet time");
endmodule

bind tpr_retimer tpr_retimer_properties u_props
(
  .clk, .nrst, .channel_mode_selector, .gate_576, .gate_1152,
  .gate_2304, .gate_select_output, .dummy_detect_enable, .retimed_pcm,
  .retimed_pcm_n, .pcm_out_1, .pcm_out_2, .monitor_g, .monitor_k,
  .monitor_l
);
